/* File: verilog/flash_cmd_consts.vh */
// Constants for the flash command controller
`ifndef FLASH_CMD_CONSTS_VH
`define FLASH_CMD_CONSTS_VH
`define CMD_READ_ARRAY   8'hFF
`define CMD_READ_ID      8'h90
`define CMD_READ_STATUS  8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_ERASE_SETUP  8'h20
`define CMD_CONFIRM      8'hD0
`define CMD_SUSPEND      8'hB0
`define CMD_PROG_SETUP   8'h40
`define CMD_PROG_SETUP_2 8'h10
`define ID_MAKER_ADDR    20'h0_0000
`define ID_PART_ADDR     20'h0_0001
`define SR_DONE_BIT      7
`define SR_PAUSED_BIT    6
`define SR_ERASE_FAIL    5
`define SR_PROG_FAIL     4
`define SR_SUPPLY_LOW    3
`define REG_CTRL         4'h0
`define REG_ADDR         4'h4
`define REG_DATA         4'h8
`define REG_STATUS       4'hC
`define OP_READ          3'h0
`define OP_WRITE         3'h1
`define OP_READ_ARRAY    3'h2
`define OP_READ_ID       3'h3
`define OP_READ_STATUS   3'h4
`define OP_CLEAR_STATUS  3'h5
`define OP_ERASE         3'h6
`define OP_PROGRAM       3'h7
`define T_STROBE_NS      100
`define CLK_NS           25
`define STROBE_CYC       (((`T_STROBE_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`endif

/* File: verilog/flash_bus_cycle.v */
// One strobe cycle on the flash pins, write or read
`timescale 1ns/100ps
`include "flash_cmd_consts.vh"
module flash_bus_cycle (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        start,
  input  wire        isWrite,
  input  wire [19:0] addr,
  input  wire [7:0]  wrData,
  input  wire [7:0]  dqIn,
  output reg  [19:0] flashAddr,
  output reg  [7:0]  dqOut,
  output reg         dqOe,
  output reg         chipSel_n,
  output reg         writeEn_n,
  output reg         outEn_n,
  output reg  [7:0]  rdData,
  output reg         done
);
  localparam S_IDLE = 2'd0;
  localparam S_ACT  = 2'd1;
  localparam S_END  = 2'd2;
  reg [1:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] dqSync1_q;
  reg [7:0] dqSync2_q;
  always @(posedge ref_clk) begin
    dqSync1_q <= dqIn;
    dqSync2_q <= dqSync1_q;
  end
  always @(posedge ref_clk) begin
    if (rst) begin
      state_q <= S_IDLE; cnt_q <= 4'h0; flashAddr <= 20'h0_0000; dqOut <= 8'h00;
      dqOe <= 1'b0; chipSel_n <= 1'b1; writeEn_n <= 1'b1; outEn_n <= 1'b1;
      rdData <= 8'h00; done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        S_IDLE: if (start) begin
          flashAddr <= addr; dqOut <= wrData; dqOe <= isWrite;
          chipSel_n <= 1'b0; writeEn_n <= ~isWrite; outEn_n <= isWrite;
          cnt_q <= 4'h0; state_q <= S_ACT;
        end
        S_ACT: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == (`STROBE_CYC + 2)) begin
            if (!isWrite) rdData <= dqSync2_q;
            writeEn_n <= 1'b1; outEn_n <= 1'b1;
            state_q <= S_END;
          end
        end
        S_END: begin
          chipSel_n <= 1'b1; dqOe <= 1'b0; done <= 1'b1; state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // flash_bus_cycle

/* File: verilog/flash_cmd_ctrl.v */
// Host controller issuing command sequences to the flash
// Notes on behaviour
// - ID command, then reads at 0 and 1
// - Read-array command returns to array mode
// - Status command makes reads return status
// - Erase is setup then confirm, same block
// - Program setup then address and byte write
// - Write strobe low under chip select
// - Command ops write only defined codes in their first cycle; OP_WRITE sends whatever byte cmdByte_q holds
`timescale 1ns/100ps
`include "flash_cmd_consts.vh"
module flash_cmd_ctrl (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire [19:0] flashAddr,
  output wire [7:0]  dqOut,
  output wire        dqOe,
  input  wire [7:0]  dqIn,
  output wire        chipSel_n,
  output wire        writeEn_n,
  output wire        outEn_n,
  output reg         powerdown_reset_n,
  input  wire        ready_busy_n
);
  localparam S_IDLE = 2'd0;
  localparam S_C1   = 2'd1;
  localparam S_C2   = 2'd2;
  reg  [1:0]  state_q;
  reg  [2:0]  op_q;
  reg  [19:0] target_addr_q;
  reg  [7:0]  program_byte_q;
  reg  [7:0]  cmdByte_q;
  reg  [7:0]  result_q;
  reg  [7:0]  status_readout_q;
  reg         busy_q;
  reg         rbSync1_q;
  reg         rbSync2_q;
  reg         start_q;
  reg         isWr_q;
  reg  [19:0] cycAddr_q;
  reg  [7:0]  cycData_q;
  wire [7:0]  rdData;
  wire        done;
  wire        regWrite = avs_write && (avs_address == `REG_CTRL) && !busy_q;
  assign avs_waitrequest = avs_write && (avs_address == `REG_CTRL) && busy_q;
  function [7:0] op_code;
    input [2:0] op;
    begin
      case (op)
        `OP_READ_ARRAY:   op_code = `CMD_READ_ARRAY;
        `OP_READ_ID:      op_code = `CMD_READ_ID;
        `OP_READ_STATUS:  op_code = `CMD_READ_STATUS;
        `OP_CLEAR_STATUS: op_code = `CMD_CLEAR_STATUS;
        `OP_ERASE:        op_code = `CMD_ERASE_SETUP;
        `OP_PROGRAM:      op_code = `CMD_PROG_SETUP;
        default:          op_code = `CMD_READ_STATUS;
      endcase
    end
  endfunction
  flash_bus_cycle u_cycle (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .start     (start_q),
    .isWrite   (isWr_q),
    .addr      (cycAddr_q),
    .wrData    (cycData_q),
    .dqIn      (dqIn),
    .flashAddr (flashAddr),
    .dqOut     (dqOut),
    .dqOe      (dqOe),
    .chipSel_n (chipSel_n),
    .writeEn_n (writeEn_n),
    .outEn_n   (outEn_n),
    .rdData    (rdData),
    .done      (done)
  );
  always @(posedge ref_clk) begin
    rbSync1_q <= ready_busy_n;
    rbSync2_q <= rbSync1_q;
  end
  always @(posedge ref_clk) begin
    if (rst) begin
      state_q <= S_IDLE; op_q <= `OP_READ; target_addr_q <= 20'h0_0000;
      program_byte_q <= 8'h00; cmdByte_q <= 8'h00; result_q <= 8'h00;
      status_readout_q <= 8'h00; busy_q <= 1'b0; start_q <= 1'b0; isWr_q <= 1'b0;
      cycAddr_q <= 20'h0_0000; cycData_q <= 8'h00; powerdown_reset_n <= 1'b1;
    end else begin
      start_q <= 1'b0;
      if (avs_write && avs_address == `REG_ADDR) target_addr_q <= avs_writedata[19:0];
      if (avs_write && avs_address == `REG_DATA) begin
        program_byte_q <= avs_writedata[7:0];
        cmdByte_q      <= avs_writedata[15:8];
        powerdown_reset_n <= ~avs_writedata[16];
      end
      case (state_q)
        S_IDLE: if (regWrite) begin
          op_q <= avs_writedata[2:0]; busy_q <= 1'b1; start_q <= 1'b1;
          state_q <= S_C1; cycAddr_q <= target_addr_q;
          if (avs_writedata[2:0] == `OP_READ) begin
            isWr_q <= 1'b0;
          end else if (avs_writedata[2:0] == `OP_WRITE) begin
            isWr_q <= 1'b1; cycData_q <= cmdByte_q;
          end else begin
            isWr_q <= 1'b1; cycData_q <= op_code(avs_writedata[2:0]);
          end
        end
        S_C1: if (done) begin
          if (!isWr_q) begin
            result_q <= rdData;
            status_readout_q <= rdData;
          end
          if (op_q == `OP_ERASE) begin
            cycData_q <= `CMD_CONFIRM; start_q <= 1'b1; state_q <= S_C2;
          end else if (op_q == `OP_PROGRAM) begin
            cycData_q <= program_byte_q; start_q <= 1'b1; state_q <= S_C2;
          end else begin
            busy_q <= 1'b0; state_q <= S_IDLE;
          end
        end
        S_C2: if (done) begin
          busy_q <= 1'b0; state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
  always @* begin
    case (avs_address)
      `REG_CTRL:   avs_readdata = {29'h0, op_q};
      `REG_ADDR:   avs_readdata = {12'h000, target_addr_q};
      `REG_DATA:   avs_readdata = {15'h0000, ~powerdown_reset_n, cmdByte_q, program_byte_q};
      `REG_STATUS: avs_readdata = {14'h0000, rbSync2_q, busy_q, status_readout_q, result_q};
      default:     avs_readdata = 32'h0000_0000;
    endcase
  end
endmodule // flash_cmd_ctrl

/* File: sim/flash_cmd_ctrl_sva.sv */
// Pin and bus checks for the flash command controller
`timescale 1ns/100ps
module flash_cmd_ctrl_sva (
  input wire        ref_clk,
  input wire        rst,
  input wire [3:0]  avs_address,
  input wire        avs_write,
  input wire        avs_waitrequest,
  input wire [19:0] flashAddr,
  input wire [7:0]  dqOut,
  input wire        dqOe,
  input wire        chipSel_n,
  input wire        writeEn_n,
  input wire        outEn_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_WE_CS: assert property (!writeEn_n |-> !chipSel_n) else $error("write without select");
  AST_WE_OE: assert property (writeEn_n || outEn_n) else $error("both strobes low");
  AST_DRIVE: assert property (dqOe |-> outEn_n) else $error("drive during read");
  AST_WAIT: assert property (avs_waitrequest |-> avs_write && avs_address == 4'h0)
    else $error("stall outside control write");
  AST_WE_LEN: assert property ($fell(writeEn_n) |=> !writeEn_n [*6]) else $error("short strobe");
  AST_HOLD: assert property (!writeEn_n && $past(!writeEn_n) |-> $stable(flashAddr) && $stable(dqOut))
    else $error("address or data moved");
  AST_RISE: assert property ($rose(writeEn_n) |-> !chipSel_n && dqOe) else $error("early release");
  AST_RST: assert property ($fell(rst) |-> chipSel_n && writeEn_n && outEn_n && !dqOe)
    else $error("strobes active after reset");
endmodule // flash_cmd_ctrl_sva
bind flash_cmd_ctrl flash_cmd_ctrl_sva u_sva (.ref_clk, .rst, .avs_address, .avs_write,
  .avs_waitrequest, .flashAddr, .dqOut, .dqOe, .chipSel_n, .writeEn_n, .outEn_n);

/* File: sim/flash_dev_model.sv */
// Behavioural flash device behind the controller pins
`timescale 1ns/100ps
module flash_dev_model #(
  parameter [7:0] MAKER_ID = 8'h3C, // Arbitrary value
  parameter [7:0] PART_ID  = 8'h5A, // Arbitrary value
  parameter       BUSY_NS  = 2000
) (
  input  wire [19:0] flashAddr,
  input  wire [7:0]  dqOut,
  input  wire        chipSel_n,
  input  wire        writeEn_n,
  input  wire        outEn_n,
  input  wire        powerdown_reset_n,
  input  wire        vppHigh,
  output wire [7:0]  dqIn,
  output reg         ready_busy_n = 1'b1
);
  reg [7:0] mem [0:15];
  reg [7:0] sr = 8'h80;
  reg [1:0] mode = 2'h0, pend = 2'h0;
  integer   i;
  wire [7:0] rd = mode == 2 ? sr : mode == 1 ? (flashAddr[0] ? PART_ID : MAKER_ID)
                  : mem[flashAddr[3:0]];
  assign dqIn = (!chipSel_n && !outEn_n) ? rd : ~rd;
  initial for (i = 0; i < 16; i = i + 1) mem[i] = 8'hFF;
  always @(negedge powerdown_reset_n) begin mode = 0; pend = 0; sr = 8'h80; end
  always @(negedge ready_busy_n) begin #(BUSY_NS); sr[7] = 1; ready_busy_n = 1; end
  always @(posedge writeEn_n) if (!chipSel_n && powerdown_reset_n) begin
    if (pend != 0) begin
      mode = 2;
      if (!vppHigh) sr[3] = 1;
      else if (pend == 2 || dqOut == 8'hD0) begin
        for (i = 0; i < 16; i = i + 1) if (pend == 1) mem[i] = 8'hFF;
        if (pend == 2) mem[flashAddr[3:0]] = dqOut;
        sr[7] = 0;
        ready_busy_n = 0;
      end
      pend = 0;
    end else case (dqOut)
      8'hFF: if (ready_busy_n) mode = 0;
      8'h90: mode = 1;
      8'h70: mode = 2;
      8'h50: sr[5:3] = 3'h0;
      8'h20: pend = 1;
      8'h40, 8'h10: pend = 2;
      default: ;
    endcase
  end
endmodule // flash_dev_model

/* File: sim/flash_cmd_ctrl_tb_top.sv */
// Testbench: controller against the flash device model
`timescale 1ns/100ps
module flash_cmd_ctrl_tb_top;
  localparam [7:0] MAKER = 8'h3C, PART = 8'h5A; // Arbitrary values
  reg         ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0, vppHigh = 1;
  reg  [3:0]  avs_address = 4'h0;
  reg  [31:0] avs_writedata = 32'h0000_0000, rdq;
  reg  [7:0]  lfsr = 8'h13, b, em [0:15];
  wire [31:0] avs_readdata;
  wire [19:0] flashAddr;
  wire [7:0]  dqOut, dqIn;
  wire        avs_waitrequest, dqOe, chipSel_n, writeEn_n, outEn_n, pdReset_n, rdyBusy_n;
  integer     fails = 0, n_compared = 0;
  flash_cmd_ctrl dut (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .flashAddr, .dqOut, .dqOe, .dqIn, .chipSel_n,
    .writeEn_n, .outEn_n, .powerdown_reset_n(pdReset_n), .ready_busy_n(rdyBusy_n));
  flash_dev_model #(.MAKER_ID(MAKER), .PART_ID(PART)) dev (.flashAddr, .dqOut, .chipSel_n,
    .writeEn_n, .outEn_n, .powerdown_reset_n(pdReset_n), .vppHigh, .dqIn,
    .ready_busy_n(rdyBusy_n));
  initial forever #12.5 ref_clk = ~ref_clk;
  function [7:0] nx(input [7:0] v); nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]}; endfunction
  task bus(input [3:0] a, input w, input [31:0] d); begin
    @(posedge ref_clk);
    avs_address <= a; avs_write <= w; avs_read <= !w; avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    rdq = avs_readdata;
    avs_write <= 1'b0; avs_read <= 1'b0;
  end endtask
  task op(input [2:0] c, input [19:0] a, input [15:0] d); integer n; begin
    bus(4'h4, 1'b1, {12'h000, a}); bus(4'h8, 1'b1, {16'h0000, d}); bus(4'h0, 1'b1, {29'h0, c});
    n = 0; rdq = 32'h0000_0000;
    while (rdq[17:16] !== 2'b10 && n < 500) begin bus(4'hC, 1'b0, 32'h0000_0000); n = n + 1; end
    if (n >= 500) begin fails = fails + 1; $display("MISMATCH busy exp 0 got 1"); end
  end endtask
  task chk(input [7:0] e); begin
    n_compared = n_compared + 1;
    if (rdq[7:0] !== e) begin fails = fails + 1; $display("MISMATCH readback exp %h got %h", e, rdq[7:0]); end
  end endtask
  task rd(input [19:0] a, input [7:0] e); begin op(3'h0, a, 16'h0000); chk(e); end endtask
  task report_and_stop; begin
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  initial begin #1_000_000; fails = fails + 1; report_and_stop; end
  initial begin
    foreach (em[j]) em[j] = 8'hFF;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(20'h0_0003, em[3]);
    lfsr = nx(lfsr); b = lfsr; em[5] = b;
    op(3'h7, 20'h0_0005, {8'h00, b}); rd(20'h0_0000, 8'h80);
    op(3'h2, 20'h0_0000, 16'h0000); rd(20'h0_0005, em[5]); rd(20'h0_0005, em[5]);
    lfsr = nx(lfsr); em[9] = lfsr;
    op(3'h1, 20'h0_0009, 16'h1000); op(3'h1, 20'h0_0009, {lfsr, 8'h00});
    op(3'h2, 20'h0_0000, 16'h0000); rd(20'h0_0009, em[9]);
    $display("test program done");
    vppHigh <= 1'b0;
    op(3'h3, 20'h0_0000, 16'h0000); rd(20'h0_0000, MAKER); rd(20'h0_0001, PART);
    op(3'h7, 20'h0_0002, 16'h0000); rd(20'h0_0000, 8'h88);
    op(3'h1, 20'h0_0000, 16'h0000); rd(20'h0_0000, 8'h88);
    op(3'h5, 20'h0_0000, 16'h0000); rd(20'h0_0000, 8'h80);
    op(3'h2, 20'h0_0000, 16'h0000); rd(20'h0_0002, em[2]);
    $display("test supply done");
    vppHigh <= 1'b1;
    foreach (em[j]) em[j] = 8'hFF;
    op(3'h6, 20'h0_0005, 16'h0000); rd(20'h0_0000, 8'h80);
    op(3'h2, 20'h0_0000, 16'h0000); rd(20'h0_0009, em[9]);
    op(3'h4, 20'h0_0000, 16'h0000); rd(20'h0_0003, 8'h80);
    bus(4'h8, 1'b1, 32'h0001_0000); bus(4'h8, 1'b1, 32'h0000_0000); rd(20'h0_0005, em[5]);
    bus(4'h1, 1'b0, 32'h0000_0000); chk(8'h00);
    $display("test erase done");
    report_and_stop;
  end
endmodule // flash_cmd_ctrl_tb_top
